// >>> design/sebs_pkg.sv
package sebs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int PROG_TIME_MS = 5;
  // longest time, rounds down
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int MEM_AW = 15;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  localparam logic [2:0] WP_REGION = 3'h7;
  localparam logic [14:0] ADDR_RST = 15'h0000;
  // pin order {straps, protect, data, clock}; bus idles high
  localparam logic [5:0] SYNC_RST = 6'h03;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV,
    ST_AHI,
    ST_ALO,
    ST_WDAT,
    ST_WEND,
    ST_RD,
    ST_RACK,
    ST_RWAIT,
    ST_PROG
  } sebs_state_t;
endpackage

// >>> design/sebs_buf2.sv
`timescale 1ns/1ns
module sebs_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = sebs_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);

  logic [W-1:0] mem_q [0:DEPTH-1];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != FULL) && !flush;
  assign out_valid = (cnt_q != '0) && !flush;
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PLAST) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PLAST) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule // sebs_buf2

// >>> design/sebs_slave.sv
`timescale 1ns/1ns
module sebs_slave #(
  parameter logic [3:0] TYPE_CODE = 4'h6, // arbitrary value
  parameter int PROG_CYCLES = sebs_pkg::PROG_CYCLES,
  parameter int MEM_AW = sebs_pkg::MEM_AW
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic [2:0] select_strap_pins,
  input wire logic wp_pin,
  output logic prog_busy
);
  localparam int PW = $clog2(PROG_CYCLES + 1);
  localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);

  sebs_pkg::sebs_state_t st_q;
  sebs_pkg::sebs_state_t nxt_q;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] filt_q;
  logic [1:0] prev_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ahi_q;
  logic [7:0] wdat_q;
  logic [7:0] tx_q;
  logic [MEM_AW-1:0] addr_q;
  logic [MEM_AW-1:0] fetch_q;
  logic [PW-1:0] prog_cnt_q;
  logic ack_q;
  logic drv_q;
  logic mack_q;
  logic rd_mode_q;
  logic wp_lat_q;
  logic [7:0] mem_q [0:(2**MEM_AW)-1];
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic dev_match;
  logic load_rd;
  logic mem_we;
  logic [15:0] full_addr;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_dout;

  function automatic logic is_rx(input sebs_pkg::sebs_state_t s);
    return (s == sebs_pkg::ST_DEV) || (s == sebs_pkg::ST_AHI) ||
           (s == sebs_pkg::ST_ALO) || (s == sebs_pkg::ST_WDAT);
  endfunction

  // three stages; a high counts once stages two and three are both high, a low as soon as they differ
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= sebs_pkg::SYNC_RST;
      s2_q <= sebs_pkg::SYNC_RST;
      s3_q <= sebs_pkg::SYNC_RST;
      filt_q <= sebs_pkg::SYNC_RST;
      prev_q <= sebs_pkg::SYNC_RST[1:0];
    end else begin
      s1_q <= {select_strap_pins, wp_pin, sda_pin_in, scl_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & ~(s2_q ^ s3_q));
      prev_q <= filt_q[1:0];
    end
  end

  assign scl_f = filt_q[0];
  assign sda_f = filt_q[1];
  assign scl_rise = scl_f && !prev_q[0];
  assign scl_fall = !scl_f && prev_q[0];
  // data edges only count while the clock stays high
  assign start_det = scl_f && prev_q[0] && prev_q[1] && !sda_f;
  assign stop_det = scl_f && prev_q[0] && !prev_q[1] && sda_f;

  assign dev_match = (sh_q[7:4] == TYPE_CODE) &&
                     (sh_q[3:1] == filt_q[5:3]);
  assign full_addr = {ahi_q, sh_q};
  assign load_rd = scl_fall && (st_q != sebs_pkg::ST_PROG) &&
                   !stop_det && !start_det &&
                   ((ack_q && nxt_q == sebs_pkg::ST_RD) ||
                    (st_q == sebs_pkg::ST_RACK && mack_q));
  assign mem_we = (st_q == sebs_pkg::ST_PROG) &&
                  (prog_cnt_q == PROG_LAST) &&
                  !(wp_lat_q && addr_q[MEM_AW-1 -: 3] ==
                    sebs_pkg::WP_REGION);

  // open drain: only ever pulls low, the pull-up makes the high
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe = drv_q;
  assign prog_busy = (st_q == sebs_pkg::ST_PROG);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= sebs_pkg::ST_IDLE;
      nxt_q <= sebs_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ahi_q <= 8'h00;
      wdat_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= sebs_pkg::ADDR_RST[MEM_AW-1:0];
      prog_cnt_q <= '0;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      mack_q <= 1'b0;
      rd_mode_q <= 1'b0;
      wp_lat_q <= 1'b0;
    end else if (st_q == sebs_pkg::ST_PROG) begin
      // bus is ignored until the cycle ends
      drv_q <= 1'b0;
      if (prog_cnt_q == PROG_LAST) begin
        st_q <= sebs_pkg::ST_IDLE;
        prog_cnt_q <= '0;
        addr_q <= addr_q + 1'b1;
      end else begin
        prog_cnt_q <= prog_cnt_q + 1'b1;
      end
    end else if (stop_det) begin
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      mack_q <= 1'b0;
      rd_mode_q <= 1'b0;
      cnt_q <= 4'h0;
      if (st_q == sebs_pkg::ST_WEND) begin
        st_q <= sebs_pkg::ST_PROG;
        wp_lat_q <= filt_q[2];
      end else begin
        st_q <= sebs_pkg::ST_IDLE;
      end
    end else if (start_det) begin
      st_q <= sebs_pkg::ST_DEV;
      ack_q <= 1'b0;
      drv_q <= 1'b0;
      mack_q <= 1'b0;
      rd_mode_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      if (scl_rise) begin
        if (is_rx(st_q) && !ack_q && cnt_q != sebs_pkg::BIT_LAST) begin
          sh_q <= {sh_q[6:0], sda_f};
          cnt_q <= cnt_q + 1'b1;
        end
        if (st_q == sebs_pkg::ST_RACK) begin
          if (!sda_f) begin
            mack_q <= 1'b1;
          end else begin
            st_q <= sebs_pkg::ST_RWAIT;
          end
        end
      end
      if (scl_fall) begin
        if (ack_q) begin
          // end of the ninth clock: release, or drive the first read bit, then move on
          ack_q <= 1'b0;
          drv_q <= 1'b0;
          cnt_q <= 4'h0;
          st_q <= nxt_q;
          if (load_rd) begin
            tx_q <= buf_dout;
            drv_q <= !buf_dout[7];
            addr_q <= addr_q + 1'b1;
          end
        end else if (is_rx(st_q) && cnt_q == sebs_pkg::BIT_LAST) begin
          ack_q <= 1'b1;
          drv_q <= 1'b1;
          case (st_q)
            sebs_pkg::ST_DEV: begin
              if (dev_match) begin
                // direction bit picks the path
                nxt_q <= sh_q[0] ? sebs_pkg::ST_RD
                                 : sebs_pkg::ST_AHI;
                rd_mode_q <= sh_q[0];
              end else begin
                ack_q <= 1'b0;
                drv_q <= 1'b0;
                st_q <= sebs_pkg::ST_IDLE;
              end
            end
            sebs_pkg::ST_AHI: begin
              ahi_q <= sh_q;
              nxt_q <= sebs_pkg::ST_ALO;
            end
            sebs_pkg::ST_ALO: begin
              addr_q <= full_addr[MEM_AW-1:0];
              nxt_q <= sebs_pkg::ST_WDAT;
            end
            sebs_pkg::ST_WDAT: begin
              wdat_q <= sh_q;
              nxt_q <= sebs_pkg::ST_WEND;
            end
            default: begin
              nxt_q <= sebs_pkg::ST_IDLE;
            end
          endcase
        end else if (st_q == sebs_pkg::ST_RD) begin
          if (cnt_q == sebs_pkg::TX_LAST) begin
            drv_q <= 1'b0;
            st_q <= sebs_pkg::ST_RACK;
            cnt_q <= 4'h0;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            drv_q <= !tx_q[6];
            cnt_q <= cnt_q + 1'b1;
          end
        end else if (load_rd) begin
          mack_q <= 1'b0;
          tx_q <= buf_dout;
          drv_q <= !buf_dout[7];
          addr_q <= addr_q + 1'b1;
          st_q <= sebs_pkg::ST_RD;
          cnt_q <= 4'h0;
        end
      end
    end
  end

  // prefetch ahead of the shifter; protect pin plays no part here
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_q <= sebs_pkg::ADDR_RST[MEM_AW-1:0];
    end else if (!rd_mode_q) begin
      fetch_q <= addr_q;
    end else if (buf_in_ready) begin
      fetch_q <= fetch_q + 1'b1;
    end
  end

  // array has no reset; content is kept across transfers
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem_q[addr_q] <= wdat_q;
    end
  end

  // shifter stalls on the master; buffer holds two bytes meanwhile
  sebs_buf2 #(
    .W(8),
    .DEPTH(sebs_pkg::BUF_DEPTH)
  ) u_rdbuf (
    .clk(mclk),
    .rst_b(rst_b),
    .flush(!rd_mode_q),
    .in_valid(rd_mode_q),
    .in_ready(buf_in_ready),
    .in_data(mem_q[fetch_q]),
    .out_valid(buf_out_valid),
    .out_ready(load_rd),
    .out_data(buf_dout)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  AST_OE_ON_FALL: assert property (
    $changed(sda_pin_oe) |->
      $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("data line drive changed outside clock low");

  AST_START_DEV: assert property (
    start_det && st_q != sebs_pkg::ST_PROG |=>
      st_q == sebs_pkg::ST_DEV && cnt_q == 4'h0 && !sda_pin_oe)
    else $error("start not taken");

  AST_STOP_READ: assert property (
    stop_det && (st_q == sebs_pkg::ST_RD ||
                 st_q == sebs_pkg::ST_RACK ||
                 st_q == sebs_pkg::ST_RWAIT)
    |=> st_q == sebs_pkg::ST_IDLE && !rd_mode_q)
    else $error("stop did not end the read");

  AST_STOP_PROG: assert property (
    stop_det && st_q == sebs_pkg::ST_WEND |=>
      st_q == sebs_pkg::ST_PROG && prog_cnt_q == '0)
    else $error("stop after data did not start programming");

  AST_PROG_DEAF: assert property (
    st_q == sebs_pkg::ST_PROG && prog_cnt_q != PROG_LAST |=>
      st_q == sebs_pkg::ST_PROG && !sda_pin_oe)
    else $error("bus activity broke the programming cycle");

  AST_PROG_LEN: assert property (
    $fell(prog_busy) |->
      $past(prog_cnt_q) == PROG_LAST && prog_cnt_q == '0)
    else $error("programming cycle length wrong");

  AST_ACK_MATCH: assert property (
    scl_fall && !ack_q && st_q == sebs_pkg::ST_DEV &&
    cnt_q == sebs_pkg::BIT_LAST && dev_match && !start_det &&
    !stop_det |=> sda_pin_oe && ack_q)
    else $error("matching address word not acknowledged");

  AST_NO_ACK_MISS: assert property (
    scl_fall && !ack_q && st_q == sebs_pkg::ST_DEV &&
    cnt_q == sebs_pkg::BIT_LAST && !dev_match && !start_det &&
    !stop_det |=> st_q == sebs_pkg::ST_IDLE && !sda_pin_oe)
    else $error("foreign address word answered");

  AST_DIR_READ: assert property (
    ack_q && st_q == sebs_pkg::ST_DEV |-> rd_mode_q == sh_q[0])
    else $error("direction bit not followed");

  AST_WP_GUARD: assert property (
    mem_we |-> !(wp_lat_q &&
                 addr_q[MEM_AW-1 -: 3] == sebs_pkg::WP_REGION))
    else $error("protected location written");

  AST_RACK_FREE: assert property (
    st_q == sebs_pkg::ST_RACK |-> !sda_pin_oe)
    else $error("line held during master acknowledge");

  AST_RWAIT_QUIET: assert property (
    st_q == sebs_pkg::ST_RWAIT && !start_det |=>
      !sda_pin_oe && !load_rd)
    else $error("data sent after no acknowledge");

  AST_LOAD_READY: assert property (
    load_rd |-> buf_out_valid)
    else $error("read byte taken from empty buffer");

  COV_WRITE_DONE: cover property (
    $fell(prog_busy));
  COV_READ_SEQ: cover property (
    st_q == sebs_pkg::ST_RACK && mack_q ##[1:40]
    st_q == sebs_pkg::ST_RD);
  COV_MISMATCH: cover property (
    st_q == sebs_pkg::ST_DEV ##1 st_q == sebs_pkg::ST_IDLE);
  COV_WP_BLOCK: cover property (
    prog_busy && prog_cnt_q == PROG_LAST && !mem_we);
endmodule // sebs_slave

// >>> test/sebs_master.sv
`timescale 1ns/1ns
module sebs_master (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // low phase stretched past the slave's filtered turnaround
  task automatic xbit(input logic b, output logic s);
    repeat (6) @(posedge mclk);
    sda_pull <= ~b;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    s = sda_line;
    scl <= 1'b0;
  endtask

  task automatic start();
    repeat (6) @(posedge mclk);
    sda_pull <= 1'b0;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    sda_pull <= 1'b1;
    repeat (4) @(posedge mclk);
    scl <= 1'b0;
  endtask

  task automatic stop();
    repeat (6) @(posedge mclk);
    sda_pull <= 1'b1;
    repeat (2) @(posedge mclk);
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    sda_pull <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(b[i], s);
    end
    xbit(1'b1, ack);
  endtask

  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(ack, s);
  endtask
endmodule // sebs_master

// >>> test/tb_serial_eeprom_bus_slave.sv
`timescale 1ns/1ns
module tb_serial_eeprom_bus_slave;
  localparam int PROG = 400;
  localparam logic [3:0] TC = 4'h6; // arbitrary value
  localparam logic [2:0] STRAP = 3'h5;

  logic mclk, rst_b, wp, sda_oe, prog_busy, scl, sda_pull, sda;
  logic sda_out;
  logic [2:0] strap;
  int n_mismatch = 0;
  int num_checks = 0;

  // pull-up wins unless someone pulls low
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

  sebs_slave #(.TYPE_CODE(TC), .PROG_CYCLES(PROG), .MEM_AW(15)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .scl_pin(scl), .sda_pin_in(sda),
    .sda_pin_out(sda_out), .sda_pin_oe(sda_oe), .select_strap_pins(strap),
    .wp_pin(wp), .prog_busy(prog_busy));

  sebs_master i_mst (.mclk(mclk), .sda_line(sda), .scl(scl),
    .sda_pull(sda_pull));

  always #10 mclk = ~mclk;

  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [7:0] aw(input logic rd);
    return {TC, STRAP, rd};
  endfunction

  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    i_mst.wbyte(b, a);
    chk1("ack", e, a);
  endtask

  task automatic set_addr(input logic [15:0] a);
    i_mst.start();
    send(aw(1'b0), 1'b0);
    send(a[15:8], 1'b0);
    send(a[7:0], 1'b0);
  endtask

  // poke: try a transfer while the array is programming
  task automatic byte_write(input logic [15:0] a, logic [7:0] d, bit poke);
    time t0;
    int n;
    set_addr(a);
    send(d, 1'b0);
    i_mst.stop();
    t0 = $time;
    n = 0;
    while (prog_busy !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    chk1("prog_busy", 1'b1, prog_busy);
    if (poke) begin
      i_mst.start();
      send(aw(1'b0), 1'b1);
      i_mst.stop();
    end
    while (prog_busy === 1'b1 && n < 2 * PROG) begin
      @(posedge mclk);
      n++;
    end
    chk1("prog_busy", 1'b0, prog_busy);
    // slack covers the input filter latency
    chk1("prog_len", 1'b1, ($time-t0) <= (PROG+12)*20);
  endtask

  task automatic read2(input logic [15:0] a, logic [7:0] e0, logic [7:0] e1);
    logic [7:0] d;
    set_addr(a);
    i_mst.start();
    send(aw(1'b1), 1'b0);
    i_mst.rbyte(d, 1'b0);
    chk8("rd0", e0, d);
    i_mst.rbyte(d, 1'b1);
    chk8("rd1", e1, d);
    i_mst.stop();
  endtask

  task automatic t_write_read();
    byte_write(16'h1234, 8'hA5, 1'b0);
    chk1("sda_out", 1'b0, sda_out);
    byte_write(16'h9235, 8'h3C, 1'b0);
    read2(16'h9234, 8'hA5, 8'h3C);
  endtask

  task automatic t_busy_silent();
    logic [7:0] d;
    byte_write(16'h0100, 8'h5A, 1'b1);
    set_addr(16'h0100);
    i_mst.start();
    send(aw(1'b1), 1'b0);
    i_mst.rbyte(d, 1'b1);
    chk8("rd0", 8'h5A, d);
    i_mst.rbyte(d, 1'b1);
    chk8("released", 8'hFF, d);
    i_mst.stop();
  endtask

  task automatic t_protect();
    byte_write(16'h7000, 8'h11, 1'b0);
    @(posedge mclk);
    wp <= 1'b1;
    byte_write(16'h7000, 8'h77, 1'b0);
    byte_write(16'h6FFF, 8'h66, 1'b0);
    read2(16'h6FFF, 8'h66, 8'h11);
    wp <= 1'b0;
    byte_write(16'h7FFF, 8'hC3, 1'b0);
    byte_write(16'h0000, 8'h4B, 1'b0);
    read2(16'h7FFF, 8'hC3, 8'h4B);
  endtask

  task automatic t_foreign();
    logic [7:0] w[3];
    w = '{{TC, ~STRAP, 1'b0}, {~TC, STRAP, 1'b0}, {TC, STRAP ^ 3'h1, 1'b1}};
    foreach (w[i]) begin
      i_mst.start();
      send(w[i], 1'b1);
      send(8'h00, 1'b1);
      i_mst.stop();
      repeat (10) @(posedge mclk);
      chk1("prog_busy", 1'b0, prog_busy);
    end
    read2(16'h1234, 8'hA5, 8'h3C);
  endtask

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    wp = 1'b0;
    strap = STRAP;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    t_write_read();
    t_busy_silent();
    t_protect();
    t_foreign();
    results();
  end

  // bus traffic of all scenarios takes well under this span
  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    results();
  end
endmodule // tb_serial_eeprom_bus_slave
